// [gih_ctl_model.sv]
// Purpose: controller model on the far side of the message handler
// Assumes: commands are handed over already decoded, one per pulse
// Notes: slow sets how many cycles pass before a talker byte is taken
`timescale 1ns/10ps
module gih_ctl_model (
  // clock
  input logic pclk,
  // bus lines
  output logic ren_n,
  output logic ifc_n,
  output gih_pkg::gih_byte_s cmd,
  // talker path
  input gih_pkg::gih_byte_s tx,
  output logic tx_ready
);
  import gih_pkg::*;
  int slow = 0;
  int wait_cnt = 0;
  int rx_cnt = 0;
  logic [7:0] rx_byte = 8'h00;
  initial begin
    ren_n = 1'b1;
    ifc_n = 1'b1;
    cmd = '0;
    tx_ready = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    cmd <= '{vld: 1'b1, data: b};
    @(posedge pclk);
    cmd <= '0;
    repeat (2) @(posedge pclk);
  endtask : send
  // remote enable change, then time for the pin synchroniser
  task automatic set_ren(input logic on);
    @(posedge pclk);
    ren_n <= !on;
    repeat (4) @(posedge pclk);
  endtask : set_ren
  task automatic pulse_ifc;
    @(posedge pclk);
    ifc_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ifc_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : pulse_ifc
  // takes each offered byte slow plus one cycles after it is first seen
  always @(posedge pclk) begin
    if (tx.vld === 1'b1 && tx_ready) begin
      rx_byte <= tx.data;
      rx_cnt <= rx_cnt + 1;
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx.vld === 1'b1) begin
      wait_cnt <= wait_cnt + 1;
      tx_ready <= (wait_cnt >= slow);
    end else begin
      wait_cnt <= 0;
      tx_ready <= 1'b0;
    end
  end
endmodule : gih_ctl_model

// [gih_handler.sv]
// Purpose: remote/local, lockout, polling, clear, trigger, control handling
// Assumes: cmd_i comes from same-clock handshake logic; pins are async
// Notes: zero-wait APB slave, pready always high
`timescale 1ns/10ps
module gih_handler #(
  parameter int NKEY = 8,
  parameter int LOCAL_KEY = 0,
  parameter logic [NKEY-1:0] EXEMPT_KEYS = 8'h0E
) (
  // apb
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [gih_pkg::APB_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus pins
  input logic ren_n_i,
  input logic ifc_n_i,
  output logic srq_n_o,
  output logic srq_oe,
  // decoded commands and talker bytes
  input gih_pkg::gih_byte_s cmd_i,
  output gih_pkg::gih_byte_s tx_o,
  input logic tx_ready,
  // front panel and instrument
  input logic [NKEY-1:0] keys_i,
  output logic [NKEY-1:0] keys_o,
  output logic remote_ind,
  output gih_pkg::gih_tcfg_s trig_cfg,
  output logic trig_start,
  output logic dev_clear,
  output logic cic
);
  import gih_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NKEY+1:0] in_q1_r;
  logic [NKEY+1:0] in_q2_r;
  logic ren_s;
  logic ifc_s;
  logic [NKEY-1:0] keys_s;
  logic lkey_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q1_r <= '0;
      in_q2_r <= '0;
    end else begin
      in_q1_r <= {keys_i, ~ifc_n_i, ~ren_n_i};
      in_q2_r <= in_q1_r;
    end
  end

  assign ren_s = in_q2_r[0];
  assign ifc_s = in_q2_r[1];
  assign keys_s = in_q2_r[NKEY+1:2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lkey_d_r <= 1'b0;
    end else begin
      lkey_d_r <= keys_s[LOCAL_KEY];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  logic [ADR_W-1:0] addr_r;
  logic [7:0] cmd7;
  logic ev_gtl, ev_sdc, ev_get, ev_tct, ev_llo, ev_dcl;
  logic ev_spe, ev_spd, ev_unl, ev_unt, ev_mla, ev_mta, ev_ota, ev_ppx;

  function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
    is_cmd = cmd_i.vld && (c == k);
  endfunction : is_cmd

  assign cmd7 = cmd_i.data & CMD_MASK;
  assign ev_gtl = is_cmd(cmd7, CMD_GTL);
  assign ev_sdc = is_cmd(cmd7, CMD_SDC);
  assign ev_get = is_cmd(cmd7, CMD_GET);
  assign ev_tct = is_cmd(cmd7, CMD_TCT);
  assign ev_llo = is_cmd(cmd7, CMD_LLO);
  assign ev_dcl = is_cmd(cmd7, CMD_DCL);
  assign ev_spe = is_cmd(cmd7, CMD_SPE);
  assign ev_spd = is_cmd(cmd7, CMD_SPD);
  assign ev_unl = is_cmd(cmd7, CMD_UNL);
  assign ev_unt = is_cmd(cmd7, CMD_UNT);
  assign ev_ppx = is_cmd(cmd7, CMD_PPC) || is_cmd(cmd7, CMD_PPU);
  assign ev_mla = is_cmd(cmd7, GRP_LAG | {3'h0, addr_r});
  assign ev_mta = is_cmd(cmd7, GRP_TAG | {3'h0, addr_r});
  assign ev_ota = cmd_i.vld && ((cmd7 & GRP_MASK) == GRP_TAG) && !ev_mta && !ev_unt;

  //////////////////////////////////////////////////////////////////////////////
  // addressing and controller role
  logic lads_r, tads_r, spms_r, cic_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lads_r <= 1'b0;
      tads_r <= 1'b0;
    end else if (ifc_s) begin
      lads_r <= 1'b0;
      tads_r <= 1'b0;
    end else begin
      if (ev_mla) lads_r <= 1'b1;
      else if (ev_unl) lads_r <= 1'b0;
      if (ev_mta) tads_r <= 1'b1;
      else if (ev_unt || ev_ota) tads_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spms_r <= 1'b0;
    end else if (ev_spe) begin
      spms_r <= 1'b1;
    end else if (ev_spd || ifc_s) begin
      spms_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cic_r <= 1'b0;
    end else if (ifc_s) begin
      cic_r <= 1'b0;
    end else if (ev_tct && tads_r) begin
      cic_r <= 1'b1;
    end
  end

  assign cic = cic_r;

  //////////////////////////////////////////////////////////////////////////////
  // remote/local state machine
  gih_rl_e rl_r, rl_nxt;
  logic rem, lkey_ev;

  assign lkey_ev = keys_s[LOCAL_KEY] && !lkey_d_r;

  always_comb begin
    rl_nxt = rl_r;
    case (rl_r)
      GIH_LOCS: begin
        if (ren_s && ev_mla) rl_nxt = GIH_REMS;
        else if (ev_llo) rl_nxt = GIH_LWLS;
      end
      GIH_REMS: begin
        if ((ev_gtl && lads_r) || lkey_ev) rl_nxt = GIH_LOCS;
        else if (ev_llo) rl_nxt = GIH_RWLS;
      end
      GIH_RWLS: begin
        if (ev_gtl && lads_r) rl_nxt = GIH_LWLS;
      end
      GIH_LWLS: begin
        if (ren_s && ev_mla) rl_nxt = GIH_RWLS;
      end
      default: rl_nxt = GIH_LOCS;
    endcase
    if (!ren_s) rl_nxt = GIH_LOCS;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rl_r <= GIH_LOCS;
    end else begin
      rl_r <= rl_nxt;
    end
  end

  assign rem = (rl_r == GIH_REMS) || (rl_r == GIH_RWLS);
  assign remote_ind = rem;

  // power, volume, squelch always pass; local passes except in remote with lockout
  always_comb begin
    keys_o = keys_s;
    if (rem) begin
      keys_o = keys_s & EXEMPT_KEYS;
      if (rl_r == GIH_REMS) keys_o[LOCAL_KEY] = keys_s[LOCAL_KEY];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger configuration and trigger event
  gih_tcfg_s tcfg_rem_r;
  logic trg_sw, trig_r;

  assign trig_cfg = rem ? tcfg_rem_r : TCFG_DEF;

  assign trg_sw = psel && penable && pwrite && (paddr == REG_CTRL) && pwdata[CTRL_TRG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= (ev_get || trg_sw) && rem && lads_r;
    end
  end

  assign trig_start = trig_r;

  //////////////////////////////////////////////////////////////////////////////
  // device clear, output byte, status byte, service request
  logic clr_ev, clr_r, txf_r, rqs, srq_r;
  logic [7:0] txb_r, stb_r, sre_r, stat, stb_full;
  logic tx_acc, txd_wr;
  gih_byte_s tx_r;

  assign clr_ev = ev_dcl || (ev_sdc && lads_r);
  assign tx_acc = tx_r.vld && tx_ready;
  assign txd_wr = psel && penable && pwrite && (paddr == REG_TXD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= clr_ev;
    end
  end

  assign dev_clear = clr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txf_r <= 1'b0;
      txb_r <= 8'h00;
    end else if (clr_ev) begin
      txf_r <= 1'b0;
    end else if (txd_wr && !txf_r) begin
      txf_r <= 1'b1;
      txb_r <= pwdata[7:0];
    end else if (tx_acc && !spms_r) begin
      txf_r <= 1'b0;
    end
  end

  always_comb begin
    stat = stb_r;
    stat[STB_MAV_BIT] = txf_r;
    stat[STB_RQS_BIT] = 1'b0;
    rqs = |(stat & sre_r);
    stb_full = stat;
    stb_full[STB_RQS_BIT] = rqs;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_r <= 1'b0;
    end else begin
      srq_r <= rqs;
    end
  end

  assign srq_n_o = 1'b0;
  assign srq_oe = srq_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r <= '0;
    end else begin
      tx_r.vld <= tads_r && (spms_r || txf_r) && !tx_acc && !clr_ev;
      tx_r.data <= spms_r ? stb_full : txb_r;
    end
  end

  assign tx_o = tx_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb registers
  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_STB) || (a == REG_SRE)
           || (a == REG_TCFG) || (a == REG_TXD) || (a == REG_STAT);
  endfunction : reg_hit

  logic wr;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= DEF_ADDR;
      stb_r <= 8'h00;
      sre_r <= 8'h00;
    end else if (wr) begin
      if (paddr == REG_CTRL && pwdata[ADR_W-1:0] <= MAX_ADDR) addr_r <= pwdata[ADR_W-1:0];
      if (paddr == REG_STB) stb_r <= pwdata[7:0];
      if (paddr == REG_SRE) sre_r <= pwdata[7:0];
    end
  end

  // remembered remote trigger setup, only changed while remote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcfg_rem_r <= TCFG_DEF;
    end else if (wr && paddr == REG_TCFG && rem) begin
      tcfg_rem_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata <= {27'h0, addr_r};
        REG_STB: prdata <= {24'h0, stb_full};
        REG_SRE: prdata <= {24'h0, sre_r};
        REG_TCFG: prdata <= {30'h0, trig_cfg};
        REG_TXD: prdata <= {23'h0, txf_r, txb_r};
        REG_STAT: prdata <= {25'h0, srq_r, cic_r, spms_r, tads_r, lads_r, rl_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_rem_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (rl_r == GIH_LOCS && ren_s && ev_mla) |=> (rl_r == GIH_REMS))
    else $error("remote not entered");
  a_ren_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !ren_s |=> (rl_r == GIH_LOCS) && !remote_ind)
    else $error("remote enable low did not go local");
  a_key_gate: assert property (@(posedge pclk) disable iff (!presetn)
    rem |-> ((keys_o & ~EXEMPT_KEYS & ~(NKEY'(1) << LOCAL_KEY)) == '0))
    else $error("key passed in remote");
  a_lock_key: assert property (@(posedge pclk) disable iff (!presetn)
    (rl_r == GIH_RWLS && lkey_ev && ren_s && !ev_gtl) |=> (rl_r == GIH_RWLS))
    else $error("local key left lockout");
  a_trig_local: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rem) |-> (trig_cfg == TCFG_DEF)) else $error("local trigger setup wrong");
  a_srq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    rqs |=> srq_oe) else $error("service request not raised");
  a_srq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !rqs |=> !srq_oe) else $error("service request not dropped");
  a_poll_bit6: assert property (@(posedge pclk) disable iff (!presetn)
    (tads_r && spms_r && !tx_acc && !ifc_s && $stable(stb_r) && $stable(sre_r))
    ##1 (tx_r.vld && $stable(txf_r)) |-> (tx_r.data[STB_RQS_BIT] == srq_oe))
    else $error("poll bit six wrong");
  a_ifc_unaddr: assert property (@(posedge pclk) disable iff (!presetn)
    ifc_s |=> !lads_r && !tads_r ##1 !tx_r.vld) else $error("interface clear kept address");
  a_clr_flush: assert property (@(posedge pclk) disable iff (!presetn)
    clr_ev |=> dev_clear && !txf_r && !tx_r.vld) else $error("device clear did not flush");
  a_trig_gate: assert property (@(posedge pclk) disable iff (!presetn)
    trig_start |-> $past(rem) && $past(lads_r)) else $error("trigger outside remote listener");
  a_take_ctl: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_tct && tads_r && !ifc_s) |=> cic) else $error("take control ignored");
  a_ppoll_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ev_ppx && !ifc_s |=> $stable(lads_r) && $stable(tads_r) && $stable(spms_r) && !dev_clear)
    else $error("parallel poll changed state");

  c_remote: cover property (@(posedge pclk) disable iff (!presetn)
    rl_r == GIH_LOCS ##1 rl_r == GIH_REMS);
  c_lockout: cover property (@(posedge pclk) disable iff (!presetn)
    rl_r == GIH_RWLS ##1 rl_r == GIH_LWLS);
  c_poll: cover property (@(posedge pclk) disable iff (!presetn)
    tx_acc && spms_r && tx_r.data[STB_RQS_BIT]);
  c_trig: cover property (@(posedge pclk) disable iff (!presetn) trig_start);
endmodule : gih_handler

// [gih_handler_tb_top.sv]
// Purpose: self-checking bench for the interface message handler
// Assumes: bus address 14 after reset, controller model on the far side
// Notes: trigger and clear pulses are counted by monitors
`timescale 1ns/10ps
module gih_handler_tb_top;
  import gih_pkg::*;
  localparam logic [7:0] MLA = GRP_LAG | {3'h0, DEF_ADDR};
  localparam logic [7:0] MTA = GRP_TAG | {3'h0, DEF_ADDR};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic erb;
  logic ren_n;
  logic ifc_n;
  logic srq_n;
  logic srq_oe;
  gih_byte_s cmd;
  gih_byte_s tx;
  logic tx_ready;
  logic [7:0] keys_i = 8'h00;
  logic [7:0] keys_o;
  logic remote_ind;
  gih_tcfg_s trig_cfg;
  logic trig_start;
  logic dev_clear;
  logic cic;
  int n_fail = 0;
  int samples_checked = 0;
  int n_trig = 0;
  int n_clr = 0;
  int t0;
  always #10 pclk = ~pclk;
  gih_handler i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ren_n_i(ren_n), .ifc_n_i(ifc_n), .srq_n_o(srq_n), .srq_oe(srq_oe),
    .cmd_i(cmd), .tx_o(tx), .tx_ready(tx_ready), .keys_i(keys_i), .keys_o(keys_o),
    .remote_ind(remote_ind), .trig_cfg(trig_cfg), .trig_start(trig_start),
    .dev_clear(dev_clear), .cic(cic));
  gih_ctl_model i_ctl (.pclk(pclk), .ren_n(ren_n), .ifc_n(ifc_n), .cmd(cmd), .tx(tx),
    .tx_ready(tx_ready));
  always @(posedge pclk) begin
    if (trig_start === 1'b1) n_trig++;
    if (dev_clear === 1'b1) n_clr++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    erb = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string what, input logic [APB_AW-1:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask : rchk
  task automatic wait_rx(input int n0);
    for (int i = 0; i < 40 && i_ctl.rx_cnt == n0; i++) @(posedge pclk);
    chk("byte count", 32'(n0 + 1), 32'(i_ctl.rx_cnt));
  endtask : wait_rx
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk1("remote", 1'b0, remote_ind);
    chk("trig", 32'h3, 32'(trig_cfg));
    chk1("srq", 1'b0, srq_oe);
    rchk("stat", REG_STAT, 32'hFF, 32'h0);
    rchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    chk1("slverr", 1'b1, erb);
    chk1("pready", 1'b1, pready);
    $display("test reset done");
  endtask : t_reset
  task automatic t_remote;
    i_ctl.set_ren(1'b1);
    i_ctl.send(MLA);
    keys_i <= 8'hFE;
    cyc(4);
    chk1("remote", 1'b1, remote_ind);
    chk("trig", 32'h3, 32'(trig_cfg));
    chk("keys", 32'h0E, 32'(keys_o));
    apb(1'b1, REG_TCFG, 32'h1);
    cyc(2);
    chk("trig", 32'h1, 32'(trig_cfg));
    i_ctl.send(CMD_GTL);
    cyc(1);
    chk1("remote", 1'b0, remote_ind);
    chk("trig", 32'h3, 32'(trig_cfg));
    chk("keys", 32'hFE, 32'(keys_o));
    i_ctl.send(MLA);
    cyc(1);
    chk("trig", 32'h1, 32'(trig_cfg));
    @(posedge pclk);
    keys_i <= 8'h01;
    cyc(5);
    chk1("remote", 1'b0, remote_ind);
    @(posedge pclk);
    keys_i <= 8'h00;
    $display("test remote done");
  endtask : t_remote
  task automatic t_lockout;
    i_ctl.send(MLA);
    i_ctl.send(CMD_LLO);
    keys_i <= 8'hFF;
    cyc(4);
    chk("keys", 32'h0E, 32'(keys_o));
    chk1("remote", 1'b1, remote_ind);
    rchk("rl", REG_STAT, 32'h3, 32'h3);
    i_ctl.send(CMD_GTL);
    cyc(1);
    chk("keys", 32'hFF, 32'(keys_o));
    rchk("rl", REG_STAT, 32'h3, 32'h2);
    i_ctl.send(MLA);
    rchk("rl", REG_STAT, 32'h3, 32'h3);
    i_ctl.set_ren(1'b0);
    chk1("remote", 1'b0, remote_ind);
    chk("trig", 32'h3, 32'(trig_cfg));
    rchk("rl", REG_STAT, 32'h3, 32'h0);
    keys_i <= 8'h00;
    $display("test lockout done");
  endtask : t_lockout
  task automatic t_srq;
    i_ctl.slow = 3;
    apb(1'b1, REG_STB, 32'h01);
    apb(1'b1, REG_SRE, 32'h01);
    cyc(2);
    chk1("srq", 1'b1, srq_oe);
    chk1("srq pin", 1'b0, srq_n);
    rchk("stb", REG_STB, 32'hFF, 32'h41);
    i_ctl.send(MTA);
    t0 = i_ctl.rx_cnt;
    i_ctl.send(CMD_SPE);
    wait_rx(t0);
    chk("poll byte", 32'h41, 32'(i_ctl.rx_byte));
    i_ctl.send(CMD_SPD);
    apb(1'b1, REG_SRE, 32'h00);
    cyc(2);
    chk1("srq", 1'b0, srq_oe);
    i_ctl.send(CMD_UNT);
    i_ctl.slow = 0;
    $display("test service request done");
  endtask : t_srq
  task automatic t_clear_trig;
    apb(1'b1, REG_TXD, 32'h5A);
    rchk("stb", REG_STB, 32'hFF, 32'h11);
    t0 = n_clr;
    i_ctl.send(CMD_DCL);
    chk("clears", 32'(t0 + 1), 32'(n_clr));
    rchk("stb", REG_STB, 32'hFF, 32'h01);
    i_ctl.set_ren(1'b1);
    i_ctl.send(MLA);
    i_ctl.send(CMD_SDC);
    chk("clears", 32'(t0 + 2), 32'(n_clr));
    chk("trig", 32'h1, 32'(trig_cfg));
    t0 = n_trig;
    i_ctl.send(CMD_PPC);
    i_ctl.send(CMD_PPU);
    rchk("stat", REG_STAT, 32'h7, 32'h5);
    i_ctl.send(CMD_GET);
    chk("trigs", 32'(t0 + 1), 32'(n_trig));
    apb(1'b1, REG_CTRL, 32'h10E);
    cyc(3);
    chk("trigs", 32'(t0 + 2), 32'(n_trig));
    i_ctl.send(CMD_GTL);
    i_ctl.send(CMD_GET);
    chk("trigs", 32'(t0 + 2), 32'(n_trig));
    $display("test clear and trigger done");
  endtask : t_clear_trig
  task automatic t_talk_addr;
    i_ctl.send(MTA);
    t0 = i_ctl.rx_cnt;
    apb(1'b1, REG_TXD, 32'hA5);
    wait_rx(t0);
    chk("data byte", 32'hA5, 32'(i_ctl.rx_byte));
    i_ctl.send(GRP_TAG | 8'h01);
    rchk("talk", REG_STAT, 32'h8, 32'h0);
    i_ctl.send(MTA);
    i_ctl.send(CMD_TCT);
    cyc(1);
    chk1("cic", 1'b1, cic);
    i_ctl.pulse_ifc();
    chk1("cic", 1'b0, cic);
    rchk("addressed", REG_STAT, 32'h0C, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1E);
    i_ctl.send(GRP_LAG | 8'h1E);
    rchk("listen", REG_STAT, 32'h4, 32'h4);
    apb(1'b1, REG_CTRL, 32'h1F);
    rchk("addr", REG_CTRL, 32'h1F, 32'h1E);
    i_ctl.send(CMD_UNL);
    rchk("listen", REG_STAT, 32'h4, 32'h0);
    $display("test talker and address done");
  endtask : t_talk_addr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_remote();
    t_lockout();
    t_srq();
    t_clear_trig();
    t_talk_addr();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end
endmodule : gih_handler_tb_top

// [gih_pkg.sv]
// Purpose: constants and types of the bus interface message handler
// Assumes: commands arrive decoded from the acceptor handshake, ATN true
// Notes: bit 6 of the status byte is built by hardware, never stored
//
// What this block does
// - remote enable plus own listen address puts the device in remote
// - in remote only local, power, volume and squelch keys pass
// - remote indicator is lit whenever the device is in remote
// - entering remote restores the trigger setup last used in remote
// - go-to-local while listener, local key, or remote enable low -> local
// - in local the trigger setup is forced to full settle, repetitive
// - local key does nothing while lockout is set
// - lockout command in remote disables every key including local, except power, volume and squelch
// - remote enable low clears lockout, goes local, forces default trigger
// - service request asserted when any enabled status bit is true
// - serial poll plus talk address returns one eight-bit status byte
// - status byte bit six reads one while service is requested
// - parallel poll configure and unconfigure get no response
// - device clear flushes buffers, aborts commands, goes idle
// - device clear keeps settings; status changes only via cleared MAV
// - universal and selected device clear act the same
// - trigger in remote and listener starts a measurement, current setup
// - bus trigger command and software trigger are one event
// - take control while talker makes the device active controller
// - interface clear drops talker and listener state at once
// - as talker the device sends status or queued data bytes
// - bus address settable 0 to 30, kept by software across power
// - go-to-local in lockout returns panel but keeps lockout
package gih_pkg;
  localparam int APB_AW = 8;
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] MAX_ADDR = 5'h1E;
  localparam logic [ADR_W-1:0] DEF_ADDR = 5'h0E;
  // register byte offsets
  localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] REG_STB = 8'h04;
  localparam logic [APB_AW-1:0] REG_SRE = 8'h08;
  localparam logic [APB_AW-1:0] REG_TCFG = 8'h0C;
  localparam logic [APB_AW-1:0] REG_TXD = 8'h10;
  localparam logic [APB_AW-1:0] REG_STAT = 8'h14;
  localparam int CTRL_TRG_BIT = 8;
  localparam int TXD_FULL_BIT = 8;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_MAV_BIT = 4;
  // bus commands, seven bits
  localparam logic [7:0] CMD_MASK = 8'h7F;
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] GRP_MASK = 8'h60;
  localparam logic [7:0] GRP_LAG = 8'h20;
  localparam logic [7:0] GRP_TAG = 8'h40;

  typedef enum logic [1:0] {
    GIH_LOCS = 2'h0,
    GIH_REMS = 2'h1,
    GIH_RWLS = 2'h3,
    GIH_LWLS = 2'h2
  } gih_rl_e;

  typedef struct packed {
    logic full_settle;
    logic rep_retrig;
  } gih_tcfg_s;

  localparam gih_tcfg_s TCFG_DEF = 2'h3;

  typedef struct packed {
    logic vld;
    logic [7:0] data;
  } gih_byte_s;
endpackage : gih_pkg
